// *** verilog/bbcr_regs.sv ***
// Purpose: Brightness source, output mapping and user configuration registers of a backlight driver.
// Assumes: The serial host front end presents decoded single-cycle reads and writes of 16-bit words.
// Notes: Global and per-output brightness are registered; outputs lag a setting change by one and two cycles.

`timescale 1ns/1ps

module bbcr_regs
#(
    parameter int NUM_OUT = 6
)
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [9:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata,
    output logic o_rd_valid,
    input wire logic [15:0] i_pwm_brightness,
    input wire bbcr_pkg::bbcr_zone_t i_zone,
    output logic [15:0] o_global_brightness,
    output logic [NUM_OUT-1:0][15:0] o_out_brightness,
    output bbcr_pkg::bbcr_cfg_t o_cfg,
    output logic [9:0] o_slope_ms,
    output logic o_hybrid_dimming
);

    logic [15:0] src_ctrl_reg;
    logic [15:0] src_ctrl_next;
    logic [15:0] gbrt_reg;
    logic [15:0] gbrt_next;
    logic [15:0] map_low_reg;
    logic [15:0] map_low_next;
    logic [15:0] map_high_reg;
    logic [15:0] map_high_next;
    logic [15:0] ucfg_reg;
    logic [15:0] ucfg_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic [15:0] global_reg;
    logic [15:0] global_next;
    logic [9:0] slope_ms_reg;
    logic [9:0] slope_ms_next;
    logic hybrid_reg;
    logic hybrid_next;
    logic [31:0] map_all;
    logic [1:0] src_sel;
    logic post_rst_reg;

    function automatic logic hit(input logic [9:0] addr, input logic [9:0] ofs);
        return addr == ofs;
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // Register writes. Every bit is kept as written, reserved ones included, so a
    // read-modify-write from software returns exactly what it stored.
    always_comb
    begin
        src_ctrl_next = src_ctrl_reg;
        gbrt_next = gbrt_reg;
        map_low_next = map_low_reg;
        map_high_next = map_high_reg;
        ucfg_next = ucfg_reg;
        if (i_wr)
        begin
            if (hit(i_addr, bbcr_pkg::OFS_SRC_CTRL))
                src_ctrl_next = i_wdata; // RL8
            else if (hit(i_addr, bbcr_pkg::OFS_GLOBAL_BRT))
                gbrt_next = i_wdata; // RL3
            else if (hit(i_addr, bbcr_pkg::OFS_MAP_LOW))
                map_low_next = i_wdata; // RL6
            else if (hit(i_addr, bbcr_pkg::OFS_MAP_HIGH))
                map_high_next = i_wdata; // RL7
            else if (hit(i_addr, bbcr_pkg::OFS_USER_CFG))
                ucfg_next = i_wdata; // RL9
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            src_ctrl_reg <= bbcr_pkg::RST_SRC_CTRL; // RL8
            gbrt_reg <= bbcr_pkg::RST_GLOBAL_BRT; // RL3
            map_low_reg <= bbcr_pkg::RST_MAP_LOW; // RL6
            map_high_reg <= bbcr_pkg::RST_MAP_HIGH; // RL7
            ucfg_reg <= bbcr_pkg::RST_USER_CFG; // RL9
        end
        else
        begin
            src_ctrl_reg <= src_ctrl_next;
            gbrt_reg <= gbrt_next;
            map_low_reg <= map_low_next;
            map_high_reg <= map_high_next;
            ucfg_reg <= ucfg_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reads. A read in the same cycle as a write returns the old contents.
    always_comb
    begin
        rd_valid_next = i_rd;
        rdata_next = rdata_reg;
        if (i_rd)
        begin
            if (hit(i_addr, bbcr_pkg::OFS_SRC_CTRL))
                rdata_next = src_ctrl_reg;
            else if (hit(i_addr, bbcr_pkg::OFS_GLOBAL_BRT))
                rdata_next = gbrt_reg;
            else if (hit(i_addr, bbcr_pkg::OFS_MAP_LOW))
                rdata_next = map_low_reg;
            else if (hit(i_addr, bbcr_pkg::OFS_MAP_HIGH))
                rdata_next = map_high_reg;
            else if (hit(i_addr, bbcr_pkg::OFS_USER_CFG))
                rdata_next = ucfg_reg;
            else
                rdata_next = 16'h0000;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rdata_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_rd_valid = rd_valid_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Global source. Reserved codes fall back to the PWM input so the outputs never
    // stall on an undefined setting.
    assign src_sel = src_ctrl_reg[bbcr_pkg::SRC_SEL_LSB +: 2];

    always_comb
    begin
        if (src_sel == bbcr_pkg::SRC_REGISTER)
            global_next = gbrt_reg; // RL2
        else
            global_next = i_pwm_brightness; // RL1
        slope_ms_next = bbcr_pkg::bbcr_slope_ms(ucfg_reg[bbcr_pkg::SLOPE_LSB +: 3]); // RL10
        hybrid_next = ucfg_reg[bbcr_pkg::DIM_LSB +: 2] == bbcr_pkg::DIM_HYBRID; // RL11
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            global_reg <= 16'h0000;
            slope_ms_reg <= 10'h000;
            hybrid_reg <= 1'b0;
        end
        else
        begin
            global_reg <= global_next;
            slope_ms_reg <= slope_ms_next;
            hybrid_reg <= hybrid_next;
        end
    end

    assign o_global_brightness = global_reg;
    assign o_slope_ms = slope_ms_reg;
    assign o_hybrid_dimming = hybrid_reg;

    // Configuration fields come straight from the register flops.
    assign o_cfg.dither_sel = ucfg_reg[bbcr_pkg::DITHER_LSB +: 3]; // RL9
    assign o_cfg.thermal_monitor_on = ucfg_reg[bbcr_pkg::THERMAL_BIT]; // RL12
    assign o_cfg.slope_time = ucfg_reg[bbcr_pkg::SLOPE_LSB +: 3]; // RL10
    assign o_cfg.smooth_transition_on = ucfg_reg[bbcr_pkg::SMOOTH_BIT]; // RL10
    assign o_cfg.dimming_mode = ucfg_reg[bbcr_pkg::DIM_LSB +: 2]; // RL11

    ////////////////////////////////////////////////////////////////////////////
    // Output mapping. Nibble k of the joined map words is the selector of output k.
    assign map_all = {map_high_reg, map_low_reg}; // RL6 RL7

    for (genvar k = 0; k < NUM_OUT; k++)
    begin : g_out
        bbcr_out_mux u_mux
        (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_sel(map_all[k*bbcr_pkg::SEL_W +: bbcr_pkg::SEL_W]),
            .i_global(global_reg),
            .i_zone(i_zone),
            .o_brightness(o_out_brightness[k])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks. The helper flag marks the first clock after reset release.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            post_rst_reg <= 1'b0;
        else
            post_rst_reg <= 1'b1;
    end

    property p_src_pwm; // RL1
        @(posedge i_clk) disable iff (!i_nrst)
        (src_sel != bbcr_pkg::SRC_REGISTER) |=> (o_global_brightness == $past(i_pwm_brightness));
    endproperty
    a_src_pwm: assert property (p_src_pwm) else $error("global brightness did not follow the PWM input"); // RL1

    property p_src_reg; // RL2
        @(posedge i_clk) disable iff (!i_nrst)
        (src_sel == bbcr_pkg::SRC_REGISTER) |=> (o_global_brightness == $past(gbrt_reg));
    endproperty
    a_src_reg: assert property (p_src_reg) else $error("global brightness did not follow its register"); // RL2

    property p_gbrt_write; // RL3
        @(posedge i_clk) disable iff (!i_nrst)
        (i_wr && i_addr == bbcr_pkg::OFS_GLOBAL_BRT) ##1 (i_rd && !i_wr && i_addr == bbcr_pkg::OFS_GLOBAL_BRT)
        |=> o_rd_valid && (o_rdata == $past(i_wdata, 2));
    endproperty
    a_gbrt_write: assert property (p_gbrt_write) else $error("global brightness readback mismatch"); // RL3

    property p_map_low; // RL6
        @(posedge i_clk) disable iff (!i_nrst)
        (i_wr && i_addr == bbcr_pkg::OFS_MAP_LOW && i_wdata[15:12] == bbcr_pkg::SEL_GLOBAL)
        |=> ##2 (o_out_brightness[3] == $past(global_reg));
    endproperty
    a_map_low: assert property (p_map_low) else $error("output 3 selector not taken from bits 15-12"); // RL6

    property p_map_high; // RL7
        @(posedge i_clk) disable iff (!i_nrst)
        (i_wr && i_addr == bbcr_pkg::OFS_MAP_HIGH) |=> (map_high_reg == $past(i_wdata))
        ##1 ((map_high_reg == $past(i_wdata, 2)) || ($past(i_wr) && $past(i_addr) == bbcr_pkg::OFS_MAP_HIGH));
    endproperty
    a_map_high: assert property (p_map_high) else $error("high map register did not hold written value"); // RL7

    property p_src_reset; // RL8
        @(posedge i_clk) disable iff (!i_nrst)
        !post_rst_reg |-> (src_ctrl_reg == 16'h0300) && (src_sel == bbcr_pkg::SRC_PWM_INPUT);
    endproperty
    a_src_reset: assert property (p_src_reset) else $error("source control reset value wrong"); // RL8

    property p_cfg_reset; // RL9
        @(posedge i_clk) disable iff (!i_nrst)
        !post_rst_reg |-> (ucfg_reg == 16'h08B0) && (o_cfg.slope_time == 3'h5) && o_cfg.smooth_transition_on;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("user configuration reset value wrong"); // RL9

    property p_slope_ms; // RL10
        @(posedge i_clk) disable iff (!i_nrst)
        (o_cfg.slope_time == 3'h7) |=> (o_slope_ms == 10'h1F4);
    endproperty
    a_slope_ms: assert property (p_slope_ms) else $error("slope code 7h did not give 500 ms"); // RL10

    property p_hybrid; // RL11
        @(posedge i_clk) disable iff (!i_nrst)
        (i_wr && i_addr == bbcr_pkg::OFS_USER_CFG && i_wdata[1:0] == 2'h1) |=> ##1 o_hybrid_dimming;
    endproperty
    a_hybrid: assert property (p_hybrid) else $error("hybrid dimming not indicated"); // RL11

    property p_thermal; // RL12
        @(posedge i_clk) disable iff (!i_nrst)
        (i_wr && i_addr == bbcr_pkg::OFS_USER_CFG) |=> (o_cfg.thermal_monitor_on == $past(i_wdata[9]));
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal monitor enable not taken from bit 9"); // RL12

    property p_unmapped_read;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_rd && i_addr == 10'h022) |=> o_rd_valid && (o_rdata == 16'h0000);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    // One nibble is watched in the low map register and two in the high one, so that a shifted or swapped field
    // slice shows up as a wrong zone on a single output.
    property p_out0_map; // RL6
        @(posedge i_clk) disable iff (!i_nrst)
        (map_low_reg[3:0] == bbcr_pkg::SEL_ZONE4) |=> (o_out_brightness[0] == $past(i_zone.zone4));
    endproperty
    a_out0_map: assert property (p_out0_map) else $error("output 0 selector not taken from bits 3-0"); // RL6

    property p_out4_map; // RL7
        @(posedge i_clk) disable iff (!i_nrst)
        (map_high_reg[3:0] == bbcr_pkg::SEL_ZONE4) |=> (o_out_brightness[4] == $past(i_zone.zone4));
    endproperty
    a_out4_map: assert property (p_out4_map) else $error("output 4 selector not taken from bits 3-0"); // RL7

    property p_out5_map; // RL7
        @(posedge i_clk) disable iff (!i_nrst)
        (map_high_reg[7:4] == bbcr_pkg::SEL_ZONE1) |=> (o_out_brightness[5] == $past(i_zone.zone1));
    endproperty
    a_out5_map: assert property (p_out5_map) else $error("output 5 selector not taken from bits 7-4"); // RL7

    // Read valid is a one-cycle answer; a stuck valid would let a master take stale data.
    property p_rd_pulse;
        @(posedge i_clk) disable iff (!i_nrst)
        !i_rd |=> !o_rd_valid;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read valid without a read");

endmodule : bbcr_regs

// *** verilog/bbcr_pkg.sv ***
// Purpose: Shared constants and types for the backlight brightness configuration registers.
// Assumes: A 16-bit register port with printed byte offsets as addresses; one 100 MHz clock.
// Notes: Widths of one register are 16 bits; unmapped offsets read as zero.
//
// Overview of operation
// [RL1] Source selector code 0h takes global brightness from the PWM input, and codes 1h and 3h are reserved.
// [RL2] Source selector code 2h takes global brightness from the global brightness register.
// [RL3] The global brightness register is one 16-bit read-write value that resets to zero.
// [RL4] An output whose cluster selector is 0h follows the global brightness source, 0h being the reset value.
// [RL5] Selector codes 1h, 3h, 4h and 5h follow zone brightness 1, 3, 4 and 5, and code 2h also follows zone 3.
// [RL6] The low map register holds the selectors of outputs 3, 2, 1 and 0 in nibbles 15-12 down to 3-0.
// [RL7] The high map register holds output 5 in bits 7-4, output 4 in bits 3-0, and read-write reserved bits 15-8.
// [RL8] The source control register resets to 300h, with read-write reserved bits 15-2 and selector 0h.
// [RL9] The user configuration register resets to 8B0h with dither, thermal, slope and dimming fields in place.
// [RL10] Slope codes 0h to 7h mean 0, 1, 2, 50, 100, 200, 300 and 500 ms, lengthened in smooth mode; o_slope_ms gives the listed values in smooth mode too.
// [RL11] Dimming mode 0h is pure PWM dimming and 1h is 12.5 percent hybrid dimming.
// [RL12] The thermal monitor enable bit turns the die temperature monitor on when 1 and off when 0.
// [RL13] Software writes reset values back into reserved fields and treats selector code 2h with care.
// [RL14] Selector codes above 5h follow the global brightness source.

package bbcr_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;

    localparam logic [9:0] OFS_SRC_CTRL = 10'h020;
    localparam logic [9:0] OFS_GLOBAL_BRT = 10'h028;
    localparam logic [9:0] OFS_MAP_LOW = 10'h030;
    localparam logic [9:0] OFS_MAP_HIGH = 10'h032;
    localparam logic [9:0] OFS_USER_CFG = 10'h040;

    localparam logic [15:0] RST_SRC_CTRL = 16'h0300;
    localparam logic [15:0] RST_GLOBAL_BRT = 16'h0000;
    localparam logic [15:0] RST_MAP_LOW = 16'h0000;
    localparam logic [15:0] RST_MAP_HIGH = 16'h0000;
    localparam logic [15:0] RST_USER_CFG = 16'h08B0;

    localparam int SRC_SEL_LSB = 0;
    localparam int DITHER_LSB = 13;
    localparam int THERMAL_BIT = 9;
    localparam int SLOPE_LSB = 5;
    localparam int SMOOTH_BIT = 4;
    localparam int DIM_LSB = 0;
    localparam int SEL_W = 4;

    localparam logic [1:0] SRC_PWM_INPUT = 2'h0;
    localparam logic [1:0] SRC_REGISTER = 2'h2;

    localparam logic [3:0] SEL_GLOBAL = 4'h0;
    localparam logic [3:0] SEL_ZONE1 = 4'h1;
    localparam logic [3:0] SEL_ZONE2_DUP = 4'h2;
    localparam logic [3:0] SEL_ZONE3 = 4'h3;
    localparam logic [3:0] SEL_ZONE4 = 4'h4;
    localparam logic [3:0] SEL_ZONE5 = 4'h5;

    localparam logic [1:0] DIM_PWM = 2'h0;
    localparam logic [1:0] DIM_HYBRID = 2'h1;

    typedef struct packed {
        logic [15:0] zone1;
        logic [15:0] zone3;
        logic [15:0] zone4;
        logic [15:0] zone5;
    } bbcr_zone_t;

    typedef struct packed {
        logic [2:0] dither_sel;
        logic thermal_monitor_on;
        logic [2:0] slope_time;
        logic smooth_transition_on;
        logic [1:0] dimming_mode;
    } bbcr_cfg_t;

    // Nominal linear-mode slope duration in ms for each slope code.
    function automatic logic [9:0] bbcr_slope_ms(input logic [2:0] code);
        logic [9:0] ms;
        ms = 10'h000;
        case (code)
            3'h0: ms = 10'h000;
            3'h1: ms = 10'h001;
            3'h2: ms = 10'h002;
            3'h3: ms = 10'h032;
            3'h4: ms = 10'h064;
            3'h5: ms = 10'h0C8;
            3'h6: ms = 10'h12C;
            default: ms = 10'h1F4;
        endcase
        return ms;
    endfunction : bbcr_slope_ms

endpackage : bbcr_pkg

// *** verilog/bbcr_out_mux.sv ***
// Purpose: Picks the brightness one LED output follows, from its cluster selector.
// Assumes: All inputs come from logic on i_clk.
// Notes: The chosen value is registered, so it follows the selector by one cycle.

`timescale 1ns/1ps

module bbcr_out_mux
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [3:0] i_sel,
    input wire logic [15:0] i_global,
    input wire bbcr_pkg::bbcr_zone_t i_zone,
    output logic [15:0] o_brightness
);

    logic [15:0] brt_reg;
    logic [15:0] brt_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        case (i_sel)
            bbcr_pkg::SEL_GLOBAL: brt_next = i_global; // RL4
            bbcr_pkg::SEL_ZONE1: brt_next = i_zone.zone1; // RL5
            // Code 2h is kept on zone 3, since that is the only encoding printed for it.
            bbcr_pkg::SEL_ZONE2_DUP: brt_next = i_zone.zone3; // RL5
            bbcr_pkg::SEL_ZONE3: brt_next = i_zone.zone3; // RL5
            bbcr_pkg::SEL_ZONE4: brt_next = i_zone.zone4; // RL5
            bbcr_pkg::SEL_ZONE5: brt_next = i_zone.zone5; // RL5
            default: brt_next = i_global; // RL14
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            brt_reg <= 16'h0000;
        else
            brt_reg <= brt_next;
    end

    assign o_brightness = brt_reg;

    ////////////////////////////////////////////////////////////////////////////
    property p_global_follow; // RL4
        @(posedge i_clk) disable iff (!i_nrst)
        (i_sel == bbcr_pkg::SEL_GLOBAL) |=> (o_brightness == $past(i_global));
    endproperty
    a_global_follow: assert property (p_global_follow) else $error("output did not follow global brightness"); // RL4

    property p_zone_follow; // RL5
        @(posedge i_clk) disable iff (!i_nrst)
        (i_sel == bbcr_pkg::SEL_ZONE4) ##1 (i_sel == bbcr_pkg::SEL_ZONE1)
        |=> (o_brightness == $past(i_zone.zone1)) && ($past(o_brightness) == $past(i_zone.zone4, 2));
    endproperty
    a_zone_follow: assert property (p_zone_follow) else $error("output did not follow its zone brightness"); // RL5

    property p_undefined_code; // RL14
        @(posedge i_clk) disable iff (!i_nrst)
        (i_sel > bbcr_pkg::SEL_ZONE5) |=> (o_brightness == $past(i_global));
    endproperty
    a_undefined_code: assert property (p_undefined_code) else $error("undefined selector did not give global"); // RL14

endmodule : bbcr_out_mux

// *** test/bbcr_regs_bench.sv ***
// Purpose: Self-checking bench for the backlight brightness configuration registers.
// Assumes: Single-cycle read and write strobes; read data and valid appear one cycle after the read.
// Notes: Outputs are sampled 1 ns after an edge so that the registered updates have landed.

`timescale 1ns/1ps

`define CHECK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
    $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end

module bbcr_regs_bench;

    typedef struct packed {
        logic [9:0] addr;
        logic [15:0] wdata;
        logic [15:0] rexp;
    } bbcr_row_t;

    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [9:0] i_addr = 10'h000;
    logic [15:0] i_wdata = 16'h0000;
    logic [15:0] i_pwm_brightness = 16'h5A5A;
    bbcr_pkg::bbcr_zone_t i_zone = {16'hA101, 16'hB303, 16'hC404, 16'hD505};
    logic [15:0] o_rdata;
    logic o_rd_valid;
    logic [15:0] o_global_brightness;
    logic [5:0][15:0] o_out_brightness;
    bbcr_pkg::bbcr_cfg_t o_cfg;
    logic [9:0] o_slope_ms;
    logic o_hybrid_dimming;
    int fail_count = 0;
    int n_tests = 0;

    // Unmapped rows sit next to and far from mapped offsets to catch a partial address decode.
    bbcr_row_t rows [8] = '{
        '{10'h020, 16'hFFFF, 16'hFFFF}, '{10'h028, 16'hBEEF, 16'hBEEF},
        '{10'h030, 16'h5A3C, 16'h5A3C}, '{10'h032, 16'hC3A5, 16'hC3A5},
        '{10'h040, 16'hF7FF, 16'hF7FF}, '{10'h022, 16'h0001, 16'h0000},
        '{10'h021, 16'h1234, 16'h0000}, '{10'h3FE, 16'h8001, 16'h0000}};
    logic [9:0] slope_tab [8] = '{10'h000, 10'h001, 10'h002, 10'h032, 10'h064, 10'h0C8, 10'h12C, 10'h1F4};

    always #5 i_clk = ~i_clk;

    bbcr_regs #(.NUM_OUT(6)) uut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .i_pwm_brightness(i_pwm_brightness), .i_zone(i_zone),
        .o_global_brightness(o_global_brightness), .o_out_brightness(o_out_brightness), .o_cfg(o_cfg),
        .o_slope_ms(o_slope_ms), .o_hybrid_dimming(o_hybrid_dimming));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] exp_out(input logic [3:0] sel, input logic [15:0] g);
        logic [15:0] v;
        case (sel)
            4'h1: v = i_zone.zone1;
            4'h2, 4'h3: v = i_zone.zone3;
            4'h4: v = i_zone.zone4;
            4'h5: v = i_zone.zone5;
            default: v = g;
        endcase
        return v;
    endfunction : exp_out

    task automatic results;
        if (fail_count == 0 && n_tests > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        int k;
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        k = 0;
        while (o_rd_valid !== 1'b1 && k < 4)
        begin
            @(posedge i_clk);
            #1;
            k++;
        end
        `CHECK("rd_valid", 1'b1, o_rd_valid)
        d = o_rdata;
    endtask : rd

    task automatic rdchk(input string nm, input logic [9:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        `CHECK(nm, e, d)
    endtask : rdchk

    task automatic settle;
        repeat (3) @(posedge i_clk);
        #1;
    endtask : settle

    task automatic chk_reset;
        rdchk("src_ctrl_rst", 10'h020, 16'h0300);
        rdchk("global_rst", 10'h028, 16'h0000);
        rdchk("map_low_rst", 10'h030, 16'h0000);
        rdchk("map_high_rst", 10'h032, 16'h0000);
        rdchk("user_cfg_rst", 10'h040, 16'h08B0);
        `CHECK("cfg_rst", 10'h02C, o_cfg)
        `CHECK("slope_rst", 10'h0C8, o_slope_ms)
        `CHECK("hybrid_rst", 1'b0, o_hybrid_dimming)
        `CHECK("out_rst", i_pwm_brightness, o_out_brightness[5])
    endtask : chk_reset

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        fail_count++;
        results();
    end

    initial
    begin
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        chk_reset();
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wdata);
            rdchk("row", rows[i].addr, rows[i].rexp);
        end
        for (int i = 0; i < 5; i++)
        begin
            rdchk("reread", rows[i].addr, rows[i].rexp);
        end
        // A read and a write to one register in the same cycle must return the old word.
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_rd <= 1'b1;
        i_addr <= 10'h028;
        i_wdata <= 16'h4321;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
        `CHECK("rd_wr_old", 16'hBEEF, o_rdata)
        // The read is held one more cycle, back to back behind the write, and must see the new word.
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHECK("rd_after_wr", 16'h4321, o_rdata)
        rdchk("rd_wr_new", 10'h028, 16'h4321);
        wr(10'h028, 16'h1234);
        wr(10'h030, 16'h0000);
        wr(10'h032, 16'h0000);
        for (int c = 0; c < 4; c++)
        begin
            i_pwm_brightness <= 16'h5A00 | 16'(c);
            wr(10'h020, 16'h0300 | 16'(c));
            settle();
            `CHECK("global_src", (c == 2) ? 16'h1234 : (16'h5A00 | 16'(c)), o_global_brightness)
            `CHECK("out_global", (c == 2) ? 16'h1234 : (16'h5A00 | 16'(c)), o_out_brightness[0])
        end
        // The map checks below expect selector 0h to follow the register value 1234h.
        wr(10'h020, 16'h0302);
        for (int c = 0; c < 16; c++)
        begin
            wr(10'h030, {4{4'(c)}});
            wr(10'h032, {8'h00, 4'(c), 4'(c)});
            settle();
            for (int k = 0; k < 6; k++)
            begin
                `CHECK("out_sel", exp_out(4'(c), 16'h1234), o_out_brightness[k])
            end
        end
        wr(10'h030, 16'h5431);
        wr(10'h032, 16'hFF20);
        settle();
        `CHECK("out0", i_zone.zone1, o_out_brightness[0])
        `CHECK("out1", i_zone.zone3, o_out_brightness[1])
        `CHECK("out2", i_zone.zone4, o_out_brightness[2])
        `CHECK("out3", i_zone.zone5, o_out_brightness[3])
        `CHECK("out4", 16'h1234, o_out_brightness[4])
        `CHECK("out5", i_zone.zone3, o_out_brightness[5])
        wr(10'h030, 16'h4444);
        wr(10'h030, 16'h1111);
        settle();
        `CHECK("out0_zone", i_zone.zone1, o_out_brightness[0])
        for (int c = 0; c < 8; c++)
        begin
            wr(10'h040, {3'(c), 3'h2, c[0], 1'b0, 3'(c), ~c[0], 2'h0, 2'(c)});
            settle();
            `CHECK("slope_ms", slope_tab[c], o_slope_ms)
            `CHECK("hybrid", (c % 4 == 1) ? 1'b1 : 1'b0, o_hybrid_dimming)
            `CHECK("thermal", c[0], o_cfg.thermal_monitor_on)
            `CHECK("cfg_fields", {3'(c), c[0], 3'(c), ~c[0], 2'(c)}, o_cfg)
        end
        // A second reset in mid-run must bring every register back to its reset word.
        @(posedge i_clk);
        i_nrst <= 1'b0;
        #1;
        `CHECK("rst_valid", 1'b0, o_rd_valid)
        `CHECK("rst_global", 16'h0000, o_global_brightness)
        `CHECK("rst_out", 96'h0, o_out_brightness)
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        chk_reset();
        results();
    end

endmodule : bbcr_regs_bench
